// [design/kst_defs.svh]
// Timing and framing constants for the keyboard serial link
`ifndef KST_DEFS_SVH
`define KST_DEFS_SVH
`define KST_CLK_HZ 50000000
`define KST_BAUD 1200
`define KST_BIT_CYCLES (`KST_CLK_HZ / `KST_BAUD)
`define KST_HALF_CYCLES (`KST_BIT_CYCLES / 2)
// Short cell for bench runs; a real cell is far too long to simulate
`define KST_SIM_BIT_CYCLES 64
`define KST_DATA_BITS 8
`define KST_FIFO_DEPTH 16
`define KST_FIFO_AW 4
`endif

// [design/kst_fifo.sv]
// Parameterised synchronous FIFO with valid/ready on both sides
module kst_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      // Registered full flag, so ready leaves from a flop
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule

// [design/kst_host_rx.sv]
// Host end: drives keyboard reset, receives inverted 8N1 characters
`include "kst_defs.svh"
module kst_host_rx #(
  parameter int BIT_CYCLES = `KST_BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  kst_link_if.host link,
  // Keyboard reset request
  input wire logic kbd_reset_req,
  // Received characters
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic frame_err
);
  // ==========================================================
  // Keyboard reset drive
  logic kbd_rst_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kbd_rst_q <= 1'b0;
    end else begin
      kbd_rst_q <= ~kbd_reset_req;
    end
  end
  assign link.kbd_resetn = kbd_rst_q;

  // ==========================================================
  // Line synchroniser, decoded to true sense
  logic s1;
  logic s2;
  logic s3;
  logic bit_level;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      bit_level <= 1'b1;
    end else begin
      s1 <= link.line;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        bit_level <= ~s3;
      end
    end
  end

  // ==========================================================
  // Receiver
  kst_pkg::kst_state_e state;
  logic [15:0] cnt;
  logic [2:0] bit_idx;
  kst_pkg::kst_byte_t shift;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= kst_pkg::KST_IDLE;
      cnt <= 16'h0000;
      bit_idx <= 3'h0;
      shift <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      frame_err <= 1'b0;
      case (state)
        kst_pkg::KST_IDLE: begin
          cnt <= 16'h0000;
          if (!bit_level) begin
            state <= kst_pkg::KST_START;
          end
        end
        kst_pkg::KST_START: begin
          // Recheck at mid-cell rejects glitches
          if (cnt == 16'(BIT_CYCLES / 2 - 1)) begin
            cnt <= 16'h0000;
            bit_idx <= 3'h0;
            state <= bit_level ? kst_pkg::KST_IDLE : kst_pkg::KST_DATA;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        kst_pkg::KST_DATA: begin
          if (cnt == 16'(BIT_CYCLES - 1)) begin
            cnt <= 16'h0000;
            shift <= {bit_level, shift[7:1]};
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'(`KST_DATA_BITS - 1)) begin
              state <= kst_pkg::KST_STOP;
            end
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        kst_pkg::KST_STOP: begin
          // No parity cell: next cell is the stop bit
          if (cnt == 16'(BIT_CYCLES - 1)) begin
            state <= kst_pkg::KST_IDLE;
            rx_data <= shift;
            rx_valid <= bit_level;
            frame_err <= ~bit_level;
          end else begin
            cnt <= cnt + 16'h0001;
          end
        end
        default: begin
          state <= kst_pkg::KST_IDLE;
        end
      endcase
    end
  end
endmodule

// [design/kst_keyboard_tx.sv]
// Keyboard end: buffered 1200 baud 8N1 transmitter, inverted line
`include "kst_defs.svh"
module kst_keyboard_tx #(
  parameter int BIT_CYCLES = `KST_BIT_CYCLES
) (
  // Clock
  input wire logic clk,
  // Link
  kst_link_if.keyboard link,
  // Key code source
  input wire logic [7:0] key_data,
  input wire logic key_valid,
  output logic key_ready,
  // Status
  output logic busy
);
  // ==========================================================
  // Reset from host
  logic rst_n;
  assign rst_n = link.kbd_resetn;

  // ==========================================================
  // Buffer
  kst_pkg::kst_byte_t fifo_data;
  logic fifo_valid;
  logic fifo_ready;
  logic fifo_in_ready;
  kst_fifo #(.WIDTH(8), .DEPTH(`KST_FIFO_DEPTH), .AW(`KST_FIFO_AW)) i_kst_fifo (
    .clk(clk),
    .resetn(rst_n),
    .in_data(key_data),
    .in_valid(key_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );
  assign key_ready = fifo_in_ready;

  // ==========================================================
  // Bit timer
  logic [15:0] tick_cnt;
  logic tick;
  kst_pkg::kst_state_e state;
  assign tick = (tick_cnt == 16'(BIT_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 16'h0000;
    end else if (state == kst_pkg::KST_IDLE || tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  // ==========================================================
  // Frame sequencer
  kst_pkg::kst_byte_t shift;
  logic [2:0] bit_idx;
  logic line_q;
  function automatic logic line_level(input logic data_bit);
    return ~data_bit;
  endfunction
  assign fifo_ready = (state == kst_pkg::KST_IDLE);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= kst_pkg::KST_IDLE;
      shift <= 8'h00;
      bit_idx <= 3'h0;
      line_q <= 1'b0;
      busy <= 1'b0;
    end else begin
      case (state)
        kst_pkg::KST_IDLE: begin
          line_q <= 1'b0;
          busy <= fifo_valid;
          if (fifo_valid) begin
            shift <= fifo_data;
            line_q <= 1'b1;
            state <= kst_pkg::KST_START;
          end
        end
        kst_pkg::KST_START: begin
          if (tick) begin
            line_q <= line_level(shift[0]);
            bit_idx <= 3'h0;
            state <= kst_pkg::KST_DATA;
          end
        end
        kst_pkg::KST_DATA: begin
          if (tick) begin
            if (bit_idx == 3'(`KST_DATA_BITS - 1)) begin
              line_q <= 1'b0;
              state <= kst_pkg::KST_STOP;
            end else begin
              line_q <= line_level(shift[bit_idx + 3'h1]);
              bit_idx <= bit_idx + 3'h1;
            end
          end
        end
        kst_pkg::KST_STOP: begin
          if (tick) begin
            state <= kst_pkg::KST_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= kst_pkg::KST_IDLE;
        end
      endcase
    end
  end
  assign link.line = line_q;
endmodule

// [design/kst_link_if.sv]
// Interface joining keyboard transmitter and host receiver
interface kst_link_if;
  // Serial data, inverted polarity
  logic line;
  // Host-driven reset, active low
  logic kbd_resetn;
  modport keyboard (output line, input kbd_resetn);
  modport host (input line, output kbd_resetn);
endinterface

// [design/kst_pkg.sv]
// Types shared by both ends of the keyboard serial link
package kst_pkg;
  typedef logic [7:0] kst_byte_t;
  typedef enum logic [1:0] {KST_IDLE, KST_START, KST_DATA, KST_STOP} kst_state_e;
endpackage

// [testbench/keyboard_serial_transmitter_tb.sv]
// Testbench for the keyboard serial link, both ends joined
`include "kst_defs.svh"
module keyboard_serial_transmitter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = `KST_SIM_BIT_CYCLES;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic kbd_reset_req = 1'b0;
  logic key_valid = 1'b0;
  kst_pkg::kst_byte_t key_data = 8'h00;
  logic key_ready, busy, rx_valid, frame_err;
  kst_pkg::kst_byte_t rx_data;
  kst_pkg::kst_byte_t last = 8'h00;
  int error_cnt = 0;
  int checks = 0;
  int got = 0;
  int ferr = 0;
  int n;
  // ==========================================
  // Design ends and checker
  kst_link_if i_kst_link_if ();
  kst_keyboard_tx #(.BIT_CYCLES(BIT)) i_kst_keyboard_tx (.clk(clk),
    .link(i_kst_link_if.keyboard),
    .key_data(key_data), .key_valid(key_valid), .key_ready(key_ready), .busy(busy));
  kst_host_rx #(.BIT_CYCLES(BIT)) i_kst_host_rx (.clk(clk), .resetn(resetn),
    .link(i_kst_link_if.host),
    .kbd_reset_req(kbd_reset_req), .rx_data(rx_data), .rx_valid(rx_valid),
    .frame_err(frame_err));
  kst_chk #(.BIT(BIT)) i_kst_chk (.clk(clk), .resetn(resetn), .line(i_kst_link_if.line),
    .kbd_resetn(i_kst_link_if.kbd_resetn), .kbd_reset_req(kbd_reset_req),
    .busy(busy), .rx_valid(rx_valid));
  initial forever #10 clk = ~clk;
  // Pulses are one cycle, so catch them here
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      got <= got + 1;
      last <= rx_data;
    end
    if (frame_err === 1'b1) ferr <= ferr + 1;
  end
  // ==========================================
  // Tasks
  task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task send(input kst_pkg::kst_byte_t b);
    key_data <= b;
    key_valid <= 1'b1;
    do @(negedge clk); while (key_ready !== 1'b1);
    @(posedge clk);
  endtask
  // Samples mid-cell; wire value worked out from the byte
  task watch(input kst_pkg::kst_byte_t b);
    n = 0;
    while (i_kst_link_if.line !== 1'b1 && n < 4 * BIT) begin
      @(negedge clk);
      n++;
    end
    chk("start seen", 32'h1, i_kst_link_if.line);
    repeat (BIT / 2) @(negedge clk);
    chk("start", 32'h1, i_kst_link_if.line);
    for (int k = 0; k < 8; k++) begin
      repeat (BIT) @(negedge clk);
      chk("data", !b[k], i_kst_link_if.line);
    end
    repeat (BIT) @(negedge clk);
    chk("stop", 32'h0, i_kst_link_if.line);
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    send(8'hA5);
    send(8'h3C);
    key_valid <= 1'b0;
    watch(8'hA5);
    watch(8'h3C);
    repeat (BIT) @(negedge clk);
    chk("rx count", 32'h2, got);
    chk("rx data", 32'h3C, last);
    chk("frame err", 32'h0, ferr);
    chk("busy", 32'h0, busy);
    @(posedge clk);
    for (n = 0; n < 20; n++) begin
      key_data <= n[7:0];
      key_valid <= 1'b1;
      @(negedge clk);
      if (key_ready !== 1'b1) break;
      @(posedge clk);
    end
    chk("accepted", `KST_FIFO_DEPTH + 1, n);
    @(posedge clk);
    key_valid <= 1'b0;
    kbd_reset_req <= 1'b1;
    repeat (2) @(posedge clk);
    kbd_reset_req <= 1'b0;
    @(negedge clk);
    chk("reset line", 32'h0, i_kst_link_if.line);
    chk("reset busy", 32'h0, busy);
    chk("reset ready", 32'h1, key_ready);
    // Host may be mid-frame on the cut frame, let it finish
    repeat (11 * BIT) @(posedge clk);
    send(8'h5A);
    key_valid <= 1'b0;
    watch(8'h5A);
    repeat (BIT) @(negedge clk);
    chk("rx after reset", 32'h5A, last);
    chk("rx count after reset", 32'h3, got);
    chk("frame err after reset", 32'h0, ferr);
    summarize();
  end
  initial begin
    repeat (60 * BIT) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule

// [testbench/kst_chk.sv]
// Checker for the keyboard serial link, watching the wire and status
`include "kst_defs.svh"
module kst_chk #(
  parameter int BIT = `KST_BIT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link and status
  input wire logic line,
  input wire logic kbd_resetn,
  input wire logic kbd_reset_req,
  input wire logic busy,
  input wire logic rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  int run;
  int brun;
  logic line_d;
  // ==========================================
  // Run lengths, so cell timing needs no long repetition
  always_ff @(posedge clk) begin
    line_d <= line;
    // Reset counts as a whole idle cell: a frame may follow release at once
    if (!kbd_resetn) begin
      run <= BIT;
    end else begin
      run <= (line != line_d) ? 1 : run + 1;
    end
    brun <= busy ? brun + 1 : 0;
  end
  default clocking cb @(posedge clk); endclocking
  // ==========================================
  // Assertions
  property p_fall_cells;
    disable iff (!kbd_resetn) $fell(line) |-> (run % BIT) == 0;
  endproperty
  a_fall_cells: assert property (p_fall_cells) else $error("high run not whole cells");
  property p_rise_gap;
    disable iff (!kbd_resetn) $rose(line) |-> run >= BIT;
  endproperty
  a_rise_gap: assert property (p_rise_gap) else $error("low level shorter than a cell");
  property p_frame_len;
    disable iff (!kbd_resetn) $fell(busy) |-> brun == 10 * BIT;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  property p_start_bit;
    disable iff (!kbd_resetn) $rose(busy) |-> line;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not high");
  property p_idle;
    !busy |-> !line;
  endproperty
  a_idle: assert property (p_idle) else $error("idle line not at stop level");
  property p_reset_hold;
    !kbd_resetn |-> !busy && !line;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("keyboard active in reset");
  property p_req_reset;
    disable iff (!resetn) kbd_reset_req |=> !kbd_resetn;
  endproperty
  a_req_reset: assert property (p_req_reset) else $error("reset request ignored");
  property p_req_release;
    disable iff (!resetn) !kbd_reset_req && $past(resetn) |=> kbd_resetn;
  endproperty
  a_req_release: assert property (p_req_release) else $error("keyboard reset stuck");
  property p_rx_stop;
    rx_valid |-> !line;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("byte taken off stop level");
endmodule
